// ===== core/rxb_params.svh
// constants for the receive buffer and status block
// assumes a 32-bit wishbone slave with byte addresses on bits [3:0]
`ifndef RXB_PARAMS_SVH
`define RXB_PARAMS_SVH

// register offsets, byte addresses
`define RXB_OFF_STATUS   4'h0
`define RXB_OFF_CONTROL  4'h4
`define RXB_OFF_DATA     4'h8
`define RXB_OFF_CONFIG   4'hc

// status register bit positions
`define RXB_ST_RXC       7
`define RXB_ST_FE        4
`define RXB_ST_DOR       3
`define RXB_ST_UPE       2

// control register bit positions
`define RXB_CT_IRQ_EN    7
`define RXB_CT_RX_EN     4
`define RXB_CT_RX9       1
`define RXB_CT_TX9       0

// config register fields
`define RXB_CF_SIZE_HI   2
`define RXB_CF_STOP      3
`define RXB_CF_PAR_LO    4
`define RXB_CF_PAR_HI    5

// reset values and frame figures
`define RXB_SIZE_RST     3'h3
`define RXB_SIZE_NINE    3'h7
`define RXB_PAR_RST      2'h0
`define RXB_BITS_MIN     4'h5
`define RXB_BITS_EIGHT   4'h8
`define RXB_BITS_NINE    4'h9

`endif

// ===== core/rxb_pkg.sv
// types shared by the receive buffer and status block
// assumes rxb_params.svh supplies the numeric constants
package rxb_pkg;

    // frame receiver states, one-hot
    typedef enum logic [3:0]
    {
        ST_IDLE = 4'h1,
        ST_DATA = 4'h2,
        ST_PAR  = 4'h4,
        ST_STOP = 4'h8
    } rx_state_e;

    // one buffered character with its status
    typedef struct packed
    {
        logic [8:0] data;
        logic       fe;
        logic       dor;
        logic       upe;
    } rx_entry_s;

    // two-entry buffer state
    typedef struct packed
    {
        rx_entry_s [1:0] mem;
        logic            wr_ptr;
        logic            rd_ptr;
        logic [1:0]      count;
    } fifo_state_s;

endpackage

// ===== core/rxb_parity.sv
// parity checker for one received frame
// assumes data bits above the frame size are already zero
`timescale 1ns/1ps

module rxb_parity
    import rxb_pkg::*;
(
    // frame contents
    input  wire logic [8:0] data,
    input  wire logic       par_bit,
    // parity mode, upper bit enables, lower bit selects odd
    input  wire logic [1:0] par_mode,
    // mismatch result
    output logic            par_err
);

    // zero bits add nothing to the xor, so no size mask is needed
    always_comb
    begin
        par_err = par_mode[1] & (^data ^ par_bit ^ par_mode[0]);
    end

endmodule

// ===== core/rxb_fifo.sv
// two-character receive buffer with flush
// assumes the caller never pushes while full
`timescale 1ns/1ps

module rxb_fifo
    import rxb_pkg::*;
(
    // clock and synchronised reset
    input  wire logic clk,
    input  wire logic rst_n,
    // write side
    input  wire logic push,
    input  rx_entry_s push_entry,
    output logic      full,
    // read side
    input  wire logic pop,
    output rx_entry_s head,
    output logic      empty,
    // drop everything
    input  wire logic flush
);

    fifo_state_s s_q;   // registered state
    fifo_state_s s_d;   // next state

    // pointer and count update; pop on empty is ignored
    always_comb
    begin
        s_d = s_q;
        if (push && s_q.count != 2'h2)
        begin
            s_d.mem[s_q.wr_ptr] = push_entry;
            s_d.wr_ptr = ~s_q.wr_ptr;
        end
        if (pop && s_q.count != 2'h0)
        begin
            s_d.rd_ptr = ~s_q.rd_ptr;
        end
        s_d.count = s_q.count
                  + {1'b0, push && s_q.count != 2'h2}
                  - {1'b0, pop && s_q.count != 2'h0};
        if (flush)
        begin
            s_d.count  = 2'h0;
            s_d.wr_ptr = 1'b0;
            s_d.rd_ptr = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign full  = (s_q.count == 2'h2);
    assign empty = (s_q.count == 2'h0);
    assign head  = s_q.mem[s_q.rd_ptr];

    // an empty read leaves the buffer alone
    empty_pop_a: assert property (@(posedge clk) disable iff (!rst_n)
        empty && pop && !push && !flush |=> empty && $stable(s_q.rd_ptr))
        else $error("pop on empty buffer moved it");

endmodule

// ===== core/rxb_top.sv
// receive buffer, status and parity logic of a serial port, with a
// wishbone register slave
// assumes bit_strobe marks each recovered bit, rx_bit its voted level
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "rxb_params.svh"

module rxb_top
    import rxb_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // recovered serial bits
    input  wire logic        bit_strobe,
    input  wire logic        rx_bit,
    // pin ownership and interrupt
    output logic             rx_pin_owned,
    output logic             rx_irq
);

    // top state, all in one record
    typedef struct packed
    {
        rx_state_e  st;         // frame receiver state
        logic [3:0] bit_cnt;    // data bit index
        logic [8:0] shift;      // receive shift register
        logic       par_bit;    // received parity bit
        rx_entry_s  hold;       // completed frame waiting
        logic       hold_valid; // hold holds a frame
        logic       dor_pend;   // a frame was lost
        logic       rx_en;      // receiver enable
        logic       irq_en;     // receive interrupt enable
        logic       tx_ninth;   // transmit ninth bit, stored only
        logic [2:0] char_size;  // character size select
        logic [1:0] par_mode;   // parity mode
        logic       stop_sel;   // stop bit count, no effect here
        logic       ack;        // bus answer
        logic [7:0] rdata;      // read data
    } top_state_s;

    logic [1:0] rst_sync_q;   // reset release chain
    logic       rst_n;        // synchronised reset
    top_state_s s_q;          // registered state
    top_state_s s_d;          // next state

    logic       fifo_push;    // frame into buffer
    rx_entry_s  push_entry;   // entry being pushed
    logic       fifo_full;    // two characters held
    logic       fifo_pop;     // data location read
    rx_entry_s  head;         // next readable character
    logic       fifo_empty;   // nothing to read
    logic       par_err;      // parity mismatch for shifted frame
    logic       req;          // bus request present
    logic       wr_go;        // write takes effect now
    logic [7:0] rd_mux;       // read value before capture
    logic [3:0] nbits;        // data bits per frame
    logic       start_seen;   // start bit accepted this cycle
    logic       overrun;      // overrun condition this cycle

    // reset is released through two flops, asserted at once
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // buffer of two characters
    rxb_fifo i_rxb_fifo
    (
        .clk        (clk),
        .rst_n      (rst_n),
        .push       (fifo_push),
        .push_entry (push_entry),
        .full       (fifo_full),
        .pop        (fifo_pop),
        .head       (head),
        .empty      (fifo_empty),
        .flush      (~s_q.rx_en)
    );

    // parity over the shifted data
    rxb_parity i_rxb_parity
    (
        .data     (s_q.shift),
        .par_bit  (s_q.par_bit),
        .par_mode (s_q.par_mode),
        .par_err  (par_err)
    );

    // frame length from the size select; reserved codes act as eight
    always_comb
    begin
        if (s_q.char_size == `RXB_SIZE_NINE)
            nbits = `RXB_BITS_NINE;
        else if (s_q.char_size[2])
            nbits = `RXB_BITS_EIGHT;
        else
            nbits = `RXB_BITS_MIN + {2'b00, s_q.char_size[1:0]};
    end

    // read value mux; empty buffer shows zero flags and data
    always_comb
    begin
        rd_mux = 8'h00;
        case (wb_adr_i)
            `RXB_OFF_STATUS:
            begin
                rd_mux[`RXB_ST_RXC] = ~fifo_empty;
                rd_mux[`RXB_ST_FE]  = ~fifo_empty & head.fe;
                rd_mux[`RXB_ST_DOR] = ~fifo_empty & head.dor;
                rd_mux[`RXB_ST_UPE] = ~fifo_empty & head.upe;
            end
            `RXB_OFF_CONTROL:
            begin
                rd_mux[`RXB_CT_IRQ_EN] = s_q.irq_en;
                rd_mux[`RXB_CT_RX_EN]  = s_q.rx_en;
                rd_mux[`RXB_CT_RX9]    = ~fifo_empty & head.data[8];
                rd_mux[`RXB_CT_TX9]    = s_q.tx_ninth;
            end
            `RXB_OFF_DATA:
                rd_mux = fifo_empty ? 8'h00 : head.data[7:0];
            `RXB_OFF_CONFIG:
                rd_mux = {2'b00, s_q.par_mode, s_q.stop_sel,
                          s_q.char_size};
            default:
                rd_mux = 8'h00; // unmapped reads answer zero
        endcase
    end

    // bus handshake: answer one cycle after the request is seen
    assign req      = wb_cyc_i & wb_stb_i;
    assign wr_go    = req & s_q.ack & wb_we_i & wb_sel_i[0];
    // the pop happens on the answering edge, after data was captured
    assign fifo_pop = req & s_q.ack & ~wb_we_i
                    & (wb_adr_i == `RXB_OFF_DATA);

    // start and overrun detection from the current receiver state
    assign start_seen = s_q.rx_en & s_q.st == ST_IDLE & bit_strobe
                      & ~rx_bit;
    assign overrun    = start_seen & s_q.hold_valid & fifo_full;

    // frame moves to buffer whenever room exists
    assign fifo_push  = s_q.rx_en & s_q.hold_valid & ~fifo_full;
    assign push_entry = '{data: s_q.hold.data, fe: s_q.hold.fe,
                          dor: s_q.dor_pend, upe: s_q.hold.upe};

    // next state: bus, registers and frame receiver
    always_comb
    begin
        s_d = s_q;
        s_d.ack = req & ~s_q.ack;
        // capture read data in the cycle before the answer
        if (req && !s_q.ack)
            s_d.rdata = rd_mux;
        // register writes; status has nothing writable
        if (wr_go)
        begin
            case (wb_adr_i)
                `RXB_OFF_CONTROL:
                begin
                    s_d.irq_en   = wb_dat_i[`RXB_CT_IRQ_EN];
                    s_d.rx_en    = wb_dat_i[`RXB_CT_RX_EN];
                    s_d.tx_ninth = wb_dat_i[`RXB_CT_TX9];
                end
                `RXB_OFF_CONFIG:
                begin
                    s_d.char_size = wb_dat_i[`RXB_CF_SIZE_HI:0];
                    s_d.stop_sel  = wb_dat_i[`RXB_CF_STOP];
                    s_d.par_mode  =
                        wb_dat_i[`RXB_CF_PAR_HI:`RXB_CF_PAR_LO];
                end
                default:
                    s_d.rx_en = s_q.rx_en; // status writes ignored
            endcase
        end
        // handing the waiting frame over clears the lost-frame mark
        if (fifo_push)
        begin
            s_d.hold_valid = 1'b0;
            s_d.dor_pend   = 1'b0;
        end
        // frame receiver, one step per recovered bit
        case (s_q.st)
            ST_IDLE:
                if (start_seen)
                begin
                    s_d.st      = ST_DATA;
                    s_d.bit_cnt = 4'h0;
                    s_d.shift   = 9'h000; // upper bits stay zero
                    if (overrun)
                    begin
                        // the waiting frame is overwritten by the new one
                        s_d.dor_pend   = 1'b1;
                        s_d.hold_valid = 1'b0;
                    end
                end
            ST_DATA:
                if (bit_strobe)
                begin
                    s_d.shift[s_q.bit_cnt] = rx_bit;
                    s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                    if (s_q.bit_cnt == nbits - 4'h1)
                        s_d.st = s_q.par_mode[1] ? ST_PAR : ST_STOP;
                end
            ST_PAR:
                if (bit_strobe)
                begin
                    s_d.par_bit = rx_bit;
                    s_d.st      = ST_STOP;
                end
            ST_STOP:
                // only the first stop bit; a second one looks idle
                if (bit_strobe)
                begin
                    s_d.hold.data  = s_q.shift;
                    s_d.hold.fe    = ~rx_bit;
                    s_d.hold.upe   = par_err;
                    s_d.hold.dor   = 1'b0;
                    s_d.hold_valid = 1'b1;
                    s_d.st         = ST_IDLE;
                end
            default:
                s_d.st = ST_IDLE;
        endcase
        // disabling drops the frame in flight and all waiting data
        if (!s_q.rx_en)
        begin
            s_d.st         = ST_IDLE;
            s_d.hold_valid = 1'b0;
            s_d.dor_pend   = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q           <= '0;
            s_q.st        <= ST_IDLE;
            s_q.char_size <= `RXB_SIZE_RST;
            s_q.par_mode  <= `RXB_PAR_RST;
        end
        else
            s_q <= s_d;
    end

    // outputs
    assign wb_ack_o     = s_q.ack;
    assign wb_dat_o     = {24'h000000, s_q.rdata};
    assign rx_pin_owned = s_q.rx_en;
    // error flags deliberately play no part here
    assign rx_irq       = s_q.irq_en & ~fifo_empty;

    // bus answer sequence: request, answer, answer dropped
    sequence bus_req_s;
        req && !s_q.ack;
    endsequence
    sequence bus_ack_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    bus_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
        bus_req_s |=> bus_ack_s)
        else $error("bus answer not one cycle wide");

    rxc_level_a: assert property (@(posedge clk) disable iff (!rst_n)
        wb_ack_o && !wb_we_i && wb_adr_i == `RXB_OFF_STATUS
        |-> wb_dat_o[`RXB_ST_RXC] == $past(!fifo_empty))
        else $error("receive flag does not match buffer");

    flush_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        !s_q.rx_en |=> fifo_empty && !s_q.hold_valid)
        else $error("buffer not flushed while disabled");

    irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.irq_en && !fifo_empty |-> rx_irq)
        else $error("interrupt low with data and enable");

    irq_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
        fifo_empty |-> !rx_irq)
        else $error("interrupt without receive data");

    // a frame may land in the same cycle, so watch the readable head only
    status_ro_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_go && wb_adr_i == `RXB_OFF_STATUS && !fifo_empty && s_q.rx_en
        |=> $stable(head))
        else $error("status write altered error state");

    frame_err_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.rx_en && s_q.st == ST_STOP && bit_strobe
        |=> s_q.hold_valid && s_q.hold.fe == $past(!rx_bit))
        else $error("frame error does not follow stop bit");

    overrun_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        overrun && s_q.rx_en |=> s_q.dor_pend)
        else $error("overrun not flagged");

    overrun_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
        fifo_push && !overrun |=> !s_q.dor_pend)
        else $error("overrun mark kept after transfer");

    parity_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.st == ST_STOP && bit_strobe && !s_q.par_mode[1] && s_q.rx_en
        |=> !s_q.hold.upe)
        else $error("parity error with checking off");

    abandon_a: assert property (@(posedge clk) disable iff (!rst_n)
        !s_q.rx_en ##1 !s_q.rx_en |-> s_q.st == ST_IDLE)
        else $error("frame kept running while disabled");

    pin_own_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_go && wb_adr_i == `RXB_OFF_CONTROL
        |=> rx_pin_owned == $past(wb_dat_i[`RXB_CT_RX_EN]))
        else $error("pin ownership does not follow enable");

endmodule

// ===== sim/serial_tx_model.sv
// behavioural far-end transmitter feeding recovered bits to the block
// assumes the caller runs one frame at a time and waits for each task
`timescale 1ns/1ps

module serial_tx_model
#(
    parameter int GAP = 3   // bit strobes are GAP + 1 idle cycles apart
)
(
    // clock
    input  wire logic clk,
    // recovered bit stream
    output logic      bit_strobe,
    output logic      rx_bit
);
    // line idles high before the first frame
    initial
    begin
        bit_strobe = 1'b0;
        rx_bit     = 1'b1;
    end

    // one bit; level inverted off the strobe, so no stale value helps
    task automatic put_bit(input logic v);
        @(posedge clk);
        bit_strobe <= 1'b1;
        rx_bit     <= v;
        @(posedge clk);
        bit_strobe <= 1'b0;
        rx_bit     <= ~v;
        repeat (GAP) @(posedge clk);
    endtask

    // start, data lsb first, optional parity, a single stop bit
    task automatic frame(input logic [8:0] d, input int n,
                         input logic pen, input logic odd,
                         input logic bad, input logic stop);
        logic p;
        p = 1'b0;
        put_bit(1'b0);
        for (int i = 0; i < n; i++)
        begin
            put_bit(d[i]);
            p = p ^ d[i];
        end
        // bad flips the parity bit on purpose
        if (pen)
            put_bit(p ^ odd ^ bad);
        put_bit(stop);
    endtask
endmodule

// ===== sim/tb_rxb_top.sv
// self-checking bench for the receive buffer and status block
// assumes rxb_params.svh offsets and a one-cycle wishbone answer
`timescale 1ns/1ps
`include "rxb_params.svh"

module tb_rxb_top;
    logic        clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [3:0]  wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic        wb_ack_o, bit_strobe, rx_bit, rx_pin_owned, rx_irq;
    int          miscompares, n_tests, cycles, k;
    logic [3:0]  sel_en;   // byte enables for the next bus cycle
    // expected status and control bits
    localparam logic [31:0] RXC = 32'h1 << `RXB_ST_RXC;
    localparam logic [31:0] FE  = 32'h1 << `RXB_ST_FE;
    localparam logic [31:0] DOR = 32'h1 << `RXB_ST_DOR;
    localparam logic [31:0] UPE = 32'h1 << `RXB_ST_UPE;
    localparam logic [31:0] ENA = 32'h1 << `RXB_CT_RX_EN;
    localparam logic [31:0] IEN = 32'h1 << `RXB_CT_IRQ_EN;
    localparam logic [31:0] B9  = 32'h1 << `RXB_CT_RX9;
    // parity table: mode, stop select, flipped bit, error expected
    logic [1:0] pm [4] = '{2'h2, 2'h3, 2'h3, 2'h1};
    logic       sb [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic       bd [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    logic       pe [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    always #2.5 clk = ~clk;

    rxb_top i_rxb_top (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .bit_strobe(bit_strobe), .rx_bit(rx_bit),
        .rx_pin_owned(rx_pin_owned), .rx_irq(rx_irq));

    serial_tx_model i_serial_tx_model (.clk(clk), .bit_strobe(bit_strobe),
        .rx_bit(rx_bit));

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // cut a hang short; the whole run needs about 1200 cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one classic cycle; held until ack is sampled high
    task automatic wb(input logic we, input logic [3:0] a,
                      input logic [7:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        wb_sel_i <= sel_en;
        do
            @(posedge clk);
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic tx(input logic [8:0] d, input int n, input logic [1:0] m,
                      input logic bad, input logic stop);
        i_serial_tx_model.frame(d, n, m[1], m[0], bad, stop);
    endtask

    // status first, then the popping data read
    task automatic rx_char(input logic [31:0] st, input logic [31:0] d);
        wb(1'b0, `RXB_OFF_STATUS, 8'h0);
        chk(rd, st);
        wb(1'b0, `RXB_OFF_DATA, 8'h0);
        chk(rd, d);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        wb(1'b0, a, 8'h0);
        chk(rd, e);
    endtask

    initial
    begin
        clk = 0;
        rstn = 0;
        wb_cyc_i = 0;
        wb_stb_i = 0;
        wb_we_i = 0;
        wb_adr_i = 0;
        wb_sel_i = 4'h0;
        wb_dat_i = 0;
        sel_en = 4'h1;
        miscompares = 0;
        n_tests = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        // reset values, unmapped place, empty pop
        wb(1'b1, 4'h2, 8'hff);
        rd_chk(4'h2, 32'h0);
        rd_chk(`RXB_OFF_CONTROL, 32'h0);
        rd_chk(`RXB_OFF_CONFIG, 32'h3);
        rd_chk(`RXB_OFF_DATA, 32'h0);
        rd_chk(`RXB_OFF_STATUS, 32'h0);
        chk(rx_pin_owned, 1'b0);
        $display("test reset done");
        // plain character with interrupt enabled
        wb(1'b1, `RXB_OFF_CONTROL, 8'(IEN | ENA));
        repeat (2) @(posedge clk);
        chk(rx_pin_owned, 1'b1);
        tx(9'h0a5, 8, 2'h0, 1'b0, 1'b1);
        @(posedge clk);
        chk(rx_irq, 1'b1);
        rx_char(RXC, 32'ha5);
        @(posedge clk);
        chk(rx_irq, 1'b0);
        rd_chk(`RXB_OFF_STATUS, 32'h0);
        $display("test basic done");
        // bad stop bit; zero write to status must not clear the flag
        wb(1'b1, `RXB_OFF_CONTROL, 8'(ENA));
        wb(1'b1, `RXB_OFF_CONFIG, 8'h0b);
        tx(9'h03c, 8, 2'h0, 1'b0, 1'b0);
        // a good second stop bit must not hide the bad first one
        i_serial_tx_model.put_bit(1'b1);
        chk(rx_irq, 1'b0);
        wb(1'b1, `RXB_OFF_STATUS, 8'h00);
        rx_char(RXC | FE, 32'h3c);
        $display("test frame error done");
        // parity modes, stop select has no say
        for (int i = 0; i < 4; i++)
        begin
            wb(1'b1, `RXB_OFF_CONFIG, {2'h0, pm[i], sb[i], 3'h3});
            tx(9'h007, 8, pm[i], bd[i], 1'b1);
            rx_char(RXC | (pe[i] ? UPE : 32'h0), 32'h07);
        end
        $display("test parity done");
        // nine and five bit characters
        wb(1'b1, `RXB_OFF_CONFIG, 8'h07);
        tx(9'h1a5, 9, 2'h0, 1'b0, 1'b1);
        rd_chk(`RXB_OFF_CONTROL, ENA | B9);
        rx_char(RXC, 32'ha5);
        wb(1'b1, `RXB_OFF_CONFIG, 8'h00);
        tx(9'h1f5, 5, 2'h0, 1'b0, 1'b1);
        rx_char(RXC, 32'h15);
        // reserved size code 4 behaves as eight bits
        wb(1'b1, `RXB_OFF_CONFIG, 8'h04);
        tx(9'h0f0, 8, 2'h0, 1'b0, 1'b1);
        rx_char(RXC, 32'hf0);
        wb(1'b1, `RXB_OFF_CONFIG, 8'h03);
        $display("test sizes done");
        // overrun: two held, third waiting, fourth start overwrites it
        tx(9'h011, 8, 2'h0, 1'b0, 1'b1);
        tx(9'h022, 8, 2'h0, 1'b0, 1'b1);
        tx(9'h033, 8, 2'h0, 1'b0, 1'b1);
        tx(9'h044, 8, 2'h0, 1'b0, 1'b1);
        rx_char(RXC, 32'h11);
        rx_char(RXC, 32'h22);
        rx_char(RXC | DOR, 32'h44);
        tx(9'h055, 8, 2'h0, 1'b0, 1'b1);
        rx_char(RXC, 32'h55);
        $display("test overrun done");
        // disable flushes, drops a half frame, ignores strobes
        tx(9'h012, 8, 2'h0, 1'b0, 1'b1);
        wb(1'b1, `RXB_OFF_CONTROL, 8'h00);
        tx(9'h066, 8, 2'h0, 1'b0, 1'b1);
        rd_chk(`RXB_OFF_STATUS, 32'h0);
        chk(rx_pin_owned, 1'b0);
        wb(1'b1, `RXB_OFF_CONTROL, 8'(ENA));
        i_serial_tx_model.put_bit(1'b0);
        i_serial_tx_model.put_bit(1'b1);
        i_serial_tx_model.put_bit(1'b1);
        wb(1'b1, `RXB_OFF_CONTROL, 8'h00);
        wb(1'b1, `RXB_OFF_CONTROL, 8'(ENA));
        tx(9'h05a, 8, 2'h0, 1'b0, 1'b1);
        rx_char(RXC, 32'h5a);
        rd_chk(`RXB_OFF_STATUS, 32'h0);
        // a write without byte enable leaves the receiver running
        sel_en = 4'h0;
        wb(1'b1, `RXB_OFF_CONTROL, 8'h00);
        sel_en = 4'h1;
        rd_chk(`RXB_OFF_CONTROL, ENA);
        $display("test disable done");
        // software empties the buffer by reading until the flag drops
        tx(9'h0c3, 8, 2'h0, 1'b0, 1'b1);
        tx(9'h03c, 8, 2'h0, 1'b0, 1'b1);
        k = 0;
        wb(1'b0, `RXB_OFF_STATUS, 8'h0);
        while (rd[`RXB_ST_RXC] === 1'b1 && k < 4)
        begin
            wb(1'b0, `RXB_OFF_DATA, 8'h0);
            k++;
            wb(1'b0, `RXB_OFF_STATUS, 8'h0);
        end
        chk(32'(k), 32'h2);
        rd_chk(`RXB_OFF_DATA, 32'h0);
        rd_chk(`RXB_OFF_STATUS, 32'h0);
        $display("test drain done");
        summarize();
    end
endmodule
